// File: design/rsc_top.sv
// Purpose: capture boot strap pin levels on external reset release
// Assumes: strap pins and the external reset pin are asynchronous
// Notes:   i_rst_n is the power-on reset of this block only; the
//          emulator and watchdog resets arrive as event inputs
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps

// What this block does
// - low bit 7 captures serial0 input pin
// - low bit 6 captures serial0 output pin
// - low bit 5 captures serial0 clock pin
// - low bit 4 captures serial0 select pin
// - low bit 3 captures serial0 enable pin
// - low bit 2 captures audio0 d8 pin
// - low bit 1 captures audio0 d9 pin
// - low bit 0 captures audio0 d7 pin
// - high bit 7 captures audio0 d5 pin
// - high bit 6 captures audio0 d6 pin
// - high bit 5 captures host chip select
// - high bit 4 captures host data 0
// - high bit 3 captures extmem d16 pin
// - high bit 2 captures audio0 transmit frame sync
// - high bit 1 captures audio0 receive frame sync
// - high bit 0 captures audio0 data 0
// - bits 31 to 8 are reserved
// - only external reset release reloads captures
module rsc_top #(
    parameter int ADDR_W = rsc_pkg::RSC_ADDR_W,
    parameter int CAP_W  = rsc_pkg::RSC_CAP_W
) (
    // clock and reset
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst_n,

    // external reset pin, active low, asynchronous
    input  wire logic              i_ext_reset_n,

    // other reset sources, same-clock one-cycle pulses
    input  wire logic              i_emu_reset,
    input  wire logic              i_wdog_reset,

    // strap pins, asynchronous levels
    input  wire logic              i_ser0_in_twi0_data_pin,
    input  wire logic              i_ser0_out_pin,
    input  wire logic              i_ser0_clk_twi0_clk_pin,
    input  wire logic              i_ser0_select_twi1_clk_pin,
    input  wire logic              i_ser0_enable_twi1_data_pin,
    input  wire logic              i_audio0_d8_audio1_d5_ser1_in_pin,
    input  wire logic              i_audio0_d9_audio1_d4_ser1_out_pin,
    input  wire logic              i_audio0_d7_ser1_clk_pin,
    input  wire logic              i_audio0_d5_ser1_select_pin,
    input  wire logic              i_audio0_d6_ser1_enable_pin,
    input  wire logic              i_host_port_chip_select_pin,
    input  wire logic              i_host_port_data0_pin,
    input  wire logic              i_extmem_d16_host_addr0_pin,
    input  wire logic              i_audio0_tx_frame_sync_pin,
    input  wire logic              i_audio0_rx_frame_sync_pin,
    input  wire logic              i_audio0_data0_pin,

    // avalon-mm register port
    input  wire logic [ADDR_W-1:0] i_address,
    input  wire logic              i_read,
    input  wire logic              i_write,
    input  wire logic [31:0]       i_writedata,
    input  wire logic [3:0]        i_byteenable,

    // avalon-mm answer, registered in the handshake block
    output logic [31:0]            o_readdata,
    output logic                   o_waitrequest,
    output logic [1:0]             o_response,

    // captured straps for boot logic
    output logic [CAP_W-1:0]       o_strap_capture_low,
    output logic [CAP_W-1:0]       o_strap_capture_high,
    output logic                   o_capture_valid
);
    // elaboration check: the bit map is fixed at eight bits per register
    generate
        if (CAP_W != rsc_pkg::RSC_CAP_W || ADDR_W != rsc_pkg::RSC_ADDR_W) begin : g_bad
            $error("rsc_top: CAP_W must be 8 and ADDR_W must be 32");
        end
    endgenerate

    // sixteen straps plus the reset pin share one synchroniser
    localparam int SYNC_W = rsc_pkg::RSC_PINS + 1;


    // pin synchronisation
    // a strap that moves within two cycles of the release may land either way
    logic [SYNC_W-1:0] pins_async;
    logic [SYNC_W-1:0] pins_sync;

    // gather the pins so one synchroniser serves all of them; the
    // external reset travels the same depth so straps and the edge
    // line up on the same cycle
    assign pins_async = {
        i_ext_reset_n,
        i_audio0_d5_ser1_select_pin,
        i_audio0_d6_ser1_enable_pin,
        i_host_port_chip_select_pin,
        i_host_port_data0_pin,
        i_extmem_d16_host_addr0_pin,
        i_audio0_tx_frame_sync_pin,
        i_audio0_rx_frame_sync_pin,
        i_audio0_data0_pin,
        i_ser0_in_twi0_data_pin,
        i_ser0_out_pin,
        i_ser0_clk_twi0_clk_pin,
        i_ser0_select_twi1_clk_pin,
        i_ser0_enable_twi1_data_pin,
        i_audio0_d8_audio1_d5_ser1_in_pin,
        i_audio0_d9_audio1_d4_ser1_out_pin,
        i_audio0_d7_ser1_clk_pin
    };

    rsc_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_async   (pins_async),
        .o_sync    (pins_sync)
    );


    // strap bit map
    // sync index to pin, high register on the left
    //   15 audio0 d5 / ser1 select      7 ser0 in / twi0 data
    //   14 audio0 d6 / ser1 enable      6 ser0 out
    //   13 host chip select             5 ser0 clock / twi0 clock
    //   12 host data 0                  4 ser0 select / twi1 clock
    //   11 extmem d16 / host addr 0     3 ser0 enable / twi1 data
    //   10 audio0 tx frame sync         2 audio0 d8 / ser1 in
    //    9 audio0 rx frame sync         1 audio0 d9 / ser1 out
    //    8 audio0 data 0                0 audio0 d7 / ser1 clock
    wire ext_reset_n_s = pins_sync[SYNC_W-1];
    wire [CAP_W-1:0] next_low;
    wire [CAP_W-1:0] next_high;

    // low capture register bits
    assign next_low[7] = pins_sync[7];
    assign next_low[6] = pins_sync[6];
    assign next_low[5] = pins_sync[5];
    assign next_low[4] = pins_sync[4];
    assign next_low[3] = pins_sync[3];
    assign next_low[2] = pins_sync[2];
    assign next_low[1] = pins_sync[1];
    assign next_low[0] = pins_sync[0];

    // high capture register bits
    assign next_high[7] = pins_sync[15];
    assign next_high[6] = pins_sync[14];
    assign next_high[5] = pins_sync[13];
    assign next_high[4] = pins_sync[12];
    assign next_high[3] = pins_sync[11];
    assign next_high[2] = pins_sync[10];
    assign next_high[1] = pins_sync[9];
    assign next_high[0] = pins_sync[8];


    // release detection
    // one state per pin level, so each rise gives exactly one capture
    rsc_pkg::rsc_cap_state_t state;
    rsc_pkg::rsc_cap_state_t next_state;
    logic                    capture;

    // the sequencer starts in reset so a pin held high from power-up
    // still counts as a release on the first synchronised sample
    always_comb begin
        next_state = state;
        capture    = 1'b0;
        case (state)
            rsc_pkg::RSC_IN_RESET: begin
                if (ext_reset_n_s) begin
                    next_state = rsc_pkg::RSC_RELEASED;
                    capture    = 1'b1;
                end
            end
            rsc_pkg::RSC_RELEASED: begin
                if (!ext_reset_n_s) begin
                    next_state = rsc_pkg::RSC_IN_RESET;
                end
            end
            default: begin
                next_state = rsc_pkg::RSC_IN_RESET;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state <= rsc_pkg::RSC_IN_RESET;
        end else begin
            state <= next_state;
        end
    end


    // capture registers
    // loaded only by the release edge; emulator and watchdog events
    // and every bus write leave them alone
    // a power-on reset of this block clears them until the next
    // release, so boot code must see o_capture_valid first
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_strap_capture_low  <= rsc_pkg::RSC_CAP_RESET;
            o_strap_capture_high <= rsc_pkg::RSC_CAP_RESET;
            o_capture_valid      <= 1'b0;
        end else if (capture) begin
            o_strap_capture_low  <= next_low;
            o_strap_capture_high <= next_high;
            o_capture_valid      <= 1'b1;
        end
    end


    // register decode
    // full-word compare, so the captures have no aliases in the window
    wire hit_low    = (i_address == rsc_pkg::RSC_ADDR_LOW);
    wire hit_high   = (i_address == rsc_pkg::RSC_ADDR_HIGH);
    wire hit_status = (i_address == rsc_pkg::RSC_ADDR_STATUS);
    wire hit_any    = hit_low | hit_high | hit_status;

    logic [31:0] status_word;
    logic [31:0] rd_value;
    logic [1:0]  rd_resp;
    logic        wr_strobe;

    // reserved bits above the captured byte read as zero
    assign rd_value = hit_low    ? {24'h00_0000, o_strap_capture_low}  :
                      hit_high   ? {24'h00_0000, o_strap_capture_high} :
                      hit_status ? status_word : 32'h0000_0000;
    // any other word answers with a decode error and zero data
    assign rd_resp  = hit_any ? rsc_pkg::RSC_RESP_OKAY : rsc_pkg::RSC_RESP_DECERR;

    rsc_avs u_avs (
        .i_clk_sys     (i_clk_sys),
        .i_rst_n       (i_rst_n),
        .i_read        (i_read),
        .i_write       (i_write),
        .i_rd_value    (rd_value),
        .i_rd_resp     (rd_resp),
        .o_waitrequest (o_waitrequest),
        .o_readdata    (o_readdata),
        .o_response    (o_response),
        .o_wr_strobe   (wr_strobe)
    );


    // status register
    // local addition so bring-up code can see which reset last ran
    logic                        done_flag;
    logic                        emu_flag;
    logic                        wdog_flag;
    logic [rsc_pkg::RSC_CNT_W-1:0] cap_count;

    // writes to the capture registers are accepted and dropped; only
    // byte 0 of the status register holds clear bits
    wire st_wr  = wr_strobe & hit_status & i_byteenable[0];
    wire clr_dn = st_wr & i_writedata[rsc_pkg::RSC_ST_DONE];
    wire clr_em = st_wr & i_writedata[rsc_pkg::RSC_ST_EMU];
    wire clr_wd = st_wr & i_writedata[rsc_pkg::RSC_ST_WDOG];

    // sticky flags clear on write one; a new event in the same cycle
    // wins so no event is lost
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            done_flag <= 1'b0;
            emu_flag  <= 1'b0;
            wdog_flag <= 1'b0;
        end else begin
            done_flag <= capture | (done_flag & ~clr_dn);
            emu_flag  <= i_emu_reset | (emu_flag & ~clr_em);
            wdog_flag <= i_wdog_reset | (wdog_flag & ~clr_wd);
        end
    end

    // release counter wraps; it lets software see repeated releases
    // eight bits wrap after 256 releases, so compare two reads only
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cap_count <= rsc_pkg::RSC_CNT_RESET;
        end else if (capture) begin
            cap_count <= cap_count + 8'h01;
        end
    end

    // status word layout; bits not listed read as zero
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[rsc_pkg::RSC_ST_DONE] = done_flag;
        status_word[rsc_pkg::RSC_ST_EMU]  = emu_flag;
        status_word[rsc_pkg::RSC_ST_WDOG] = wdog_flag;
        status_word[rsc_pkg::RSC_ST_PIN]  = ext_reset_n_s;
        status_word[rsc_pkg::RSC_ST_CNT +: rsc_pkg::RSC_CNT_W] = cap_count;
    end
endmodule

// File: design/rsc_pkg.sv
// Purpose: shared constants for the reset strap capture block
// Assumes: byte addresses on a 32-bit Avalon-MM register port
// Notes:   status register offset and layout are local to this block
package rsc_pkg;
    // register byte addresses
    localparam logic [31:0] RSC_ADDR_LOW    = 32'h4000_0000;
    localparam logic [31:0] RSC_ADDR_HIGH   = 32'h4000_0004;
    localparam logic [31:0] RSC_ADDR_STATUS = 32'h4000_0010;

    // bus widths
    localparam int RSC_DATA_W = 32;
    localparam int RSC_ADDR_W = 32;

    // captured field layout: each register uses its low eight bits
    localparam int RSC_CAP_W   = 8;
    localparam int RSC_PINS    = 16;
    localparam logic [7:0] RSC_CAP_RESET = 8'h00;

    // status register layout
    localparam int RSC_ST_DONE  = 0;
    localparam int RSC_ST_EMU   = 1;
    localparam int RSC_ST_WDOG  = 2;
    localparam int RSC_ST_PIN   = 3;
    localparam int RSC_ST_CNT   = 8;
    localparam int RSC_CNT_W    = 8;
    localparam logic [7:0] RSC_CNT_RESET = 8'h00;

    // synchroniser depth for pin inputs
    localparam int RSC_SYNC_STAGES = 2;

    // avalon response codes
    localparam logic [1:0] RSC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] RSC_RESP_DECERR = 2'h3;

    // capture sequencer states
    typedef enum logic {
        RSC_IN_RESET,
        RSC_RELEASED
    } rsc_cap_state_t;
endpackage

// File: design/rsc_sync.sv
// Purpose: two flip-flop synchroniser for a vector of pin levels
// Assumes: each bit is an independent level; no bus coherence needed
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module rsc_sync #(
    parameter int WIDTH = 17
) (
    // clock and reset
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst_n,
    // pins and synchronised levels
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;

    // one two-stage chain per bit; reset to zero keeps a defined start
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge i_clk_sys) begin
                if (!i_rst_n) begin
                    meta[g]   <= 1'b0;
                    o_sync[g] <= 1'b0;
                end else begin
                    meta[g]   <= i_async[g];
                    o_sync[g] <= meta[g];
                end
            end
        end
    endgenerate
endmodule

// File: design/rsc_avs.sv
// Purpose: Avalon-MM slave handshake with one wait cycle per access
// Assumes: master holds its request until it sees waitrequest low
// Notes:   read data and response are latched one edge before release
`timescale 1ns/1ps
module rsc_avs (
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    // bus request
    input  wire logic        i_read,
    input  wire logic        i_write,
    // decoded answer from the register file
    input  wire logic [31:0] i_rd_value,
    input  wire logic [1:0]  i_rd_resp,
    // bus answer
    output logic             o_waitrequest,
    output logic [31:0]      o_readdata,
    output logic [1:0]       o_response,
    // write strobe, high in the cycle the master is released
    output logic             o_wr_strobe
);
    wire req    = i_read | i_write;
    wire accept = req & o_waitrequest;

    // waitrequest idles high and drops for exactly one cycle per request
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_waitrequest <= 1'b1;
            o_readdata    <= 32'h0000_0000;
            o_response    <= rsc_pkg::RSC_RESP_OKAY;
        end else begin
            o_waitrequest <= ~accept;
            if (accept) begin
                o_readdata <= i_read ? i_rd_value : 32'h0000_0000;
                o_response <= i_rd_resp;
            end
        end
    end

    // write acts at the edge where the master samples waitrequest low
    assign o_wr_strobe = i_write & ~o_waitrequest;
endmodule

// File: verif/rsc_chk.sv
// Purpose: bus and capture properties of the strap capture block
// Assumes: one clock domain, synchronous active-low reset
// Notes:   capture changes are only allowed shortly after a pin release or a block reset
`timescale 1ns/1ps
module rsc_chk #(
    parameter int ADDR_W = 32,
    parameter int CAP_W  = 8
) (
    // clock and reset
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst_n,
    input  wire logic              i_ext_reset_n,
    // bus
    input  wire logic [ADDR_W-1:0] i_address,
    input  wire logic              i_read,
    input  wire logic              i_write,
    input  wire logic [31:0]       o_readdata,
    input  wire logic              o_waitrequest,
    input  wire logic [1:0]        o_response,
    // captures
    input  wire logic [CAP_W-1:0]  o_strap_capture_low,
    input  wire logic [CAP_W-1:0]  o_strap_capture_high,
    input  wire logic              o_capture_valid
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    logic [7:0] ext_hist;
    logic [3:0] since_rst;
    // quiet: 15 edges past reset and no pin release within the last seven edges, so captures must not move
    wire quiet   = (since_rst == 4'hF) && !(|(ext_hist[6:0] & ~ext_hist[7:1]));
    wire is_low  = (i_address == rsc_pkg::RSC_ADDR_LOW);
    wire is_high = (i_address == rsc_pkg::RSC_ADDR_HIGH);
    wire is_map  = is_low || is_high || (i_address == rsc_pkg::RSC_ADDR_STATUS);
    wire done    = !o_waitrequest && (i_read || i_write);

    // pin history and time since reset release
    always_ff @(posedge i_clk_sys) begin
        ext_hist <= {ext_hist[6:0], i_ext_reset_n};
        if (!i_rst_n) begin
            since_rst <= 4'h0;
        end else if (since_rst != 4'hF) begin
            since_rst <= since_rst + 4'h1;
        end
    end

    property p_one_wait;
        (i_read || i_write) && o_waitrequest |=> !o_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("no answer one cycle after request");
    property p_wait_short;
        !o_waitrequest |=> o_waitrequest;
    endproperty
    a_wait_short: assert property (p_wait_short) else $error("waitrequest low too long");
    property p_reserved_zero;
        done && i_read && (is_low || is_high) |-> o_readdata[31:8] == 24'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");
    property p_read_low;
        done && i_read && is_low && quiet |-> o_readdata[7:0] == o_strap_capture_low;
    endproperty
    a_read_low: assert property (p_read_low) else $error("low read differs from capture");
    property p_read_high;
        done && i_read && is_high && quiet |-> o_readdata[7:0] == o_strap_capture_high;
    endproperty
    a_read_high: assert property (p_read_high) else $error("high read differs from capture");
    property p_caps_hold;
        quiet |-> $stable(o_strap_capture_low) && $stable(o_strap_capture_high);
    endproperty
    a_caps_hold: assert property (p_caps_hold) else $error("capture moved without release");
    property p_write_ignored;
        done && i_write && quiet |=> $stable(o_strap_capture_low) [*2];
    endproperty
    a_write_ignored: assert property (p_write_ignored) else $error("write changed capture");
    property p_unmapped;
        done && !is_map |-> o_response == rsc_pkg::RSC_RESP_DECERR;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_valid_sticky;
        o_capture_valid |=> o_capture_valid;
    endproperty
    a_valid_sticky: assert property (p_valid_sticky) else $error("capture valid dropped");

    c_read_low: cover property (done && i_read && is_low && quiet);
    c_capture: cover property ($rose(o_capture_valid));
    c_unmapped: cover property (done && !is_map);
endmodule

// File: verif/rsc_strap_board.sv
// Purpose: board straps and external reset pin driver
// Assumes: straps stand still a few cycles around the reset release
// Notes:   after the hold time the pins carry the inverse pattern, as in use
`timescale 1ns/1ps
module rsc_strap_board (
    // clock and command
    input  wire logic        i_clk_sys,
    input  wire logic        i_go,
    input  wire logic [15:0] i_pattern,
    // pins
    output logic             o_ext_reset_n = 1'b0,
    output logic [15:0]      o_pins = 16'h0000,
    output logic             o_busy = 1'b0
);
    logic [3:0] cnt = 4'h0;

    // pulse reset low with straps set, release, then reuse the pins
    always_ff @(posedge i_clk_sys) begin
        if (i_go && !o_busy) begin
            o_ext_reset_n <= 1'b0;
            o_pins        <= i_pattern;
            o_busy        <= 1'b1;
            cnt           <= 4'h1;
        end else if (o_busy) begin
            cnt <= cnt + 4'h1;
            if (cnt == 4'h8) begin
                o_ext_reset_n <= 1'b1;
            end
            if (cnt == 4'hC) begin
                o_pins <= ~o_pins;
                o_busy <= 1'b0;
            end
        end
    end
endmodule

// File: verif/reset_strap_capture_tb.sv
// Purpose: self-checking bench for the strap capture block
// Assumes: one wait cycle per access, captures land 3 edges after release
// Notes:   walking patterns give every strap bit its own position
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; $display("mismatch at %0t: got %0h exp %0h", $time, (g), (e)); end end
module reset_strap_capture_tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        emu = 1'b0;
    logic        wdog = 1'b0;
    logic        go = 1'b0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] addr = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic [15:0] pat = 16'h0;
    logic [15:0] p;
    logic [31:0] q;
    logic [1:0]  r;
    wire         ext_n;
    wire         busy;
    wire  [15:0] pins;
    wire  [31:0] rdata;
    wire         waitreq;
    wire  [1:0]  resp;
    wire  [7:0]  cap_lo;
    wire  [7:0]  cap_hi;
    wire         cap_v;
    int          error_cnt = 0;
    int          samples_checked = 0;

    // 200 MHz clock
    initial begin
        forever #2.5 clk = ~clk;
    end

    rsc_strap_board board (.i_clk_sys(clk), .i_go(go), .i_pattern(pat),
        .o_ext_reset_n(ext_n), .o_pins(pins), .o_busy(busy));

    rsc_top uut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ext_reset_n(ext_n),
        .i_emu_reset(emu), .i_wdog_reset(wdog),
        .i_ser0_in_twi0_data_pin(pins[15]), .i_ser0_out_pin(pins[14]),
        .i_ser0_clk_twi0_clk_pin(pins[13]), .i_ser0_select_twi1_clk_pin(pins[12]),
        .i_ser0_enable_twi1_data_pin(pins[11]), .i_audio0_d8_audio1_d5_ser1_in_pin(pins[10]),
        .i_audio0_d9_audio1_d4_ser1_out_pin(pins[9]), .i_audio0_d7_ser1_clk_pin(pins[8]),
        .i_audio0_d5_ser1_select_pin(pins[7]), .i_audio0_d6_ser1_enable_pin(pins[6]),
        .i_host_port_chip_select_pin(pins[5]), .i_host_port_data0_pin(pins[4]),
        .i_extmem_d16_host_addr0_pin(pins[3]), .i_audio0_tx_frame_sync_pin(pins[2]),
        .i_audio0_rx_frame_sync_pin(pins[1]), .i_audio0_data0_pin(pins[0]),
        .i_address(addr), .i_read(rd), .i_write(wr), .i_writedata(wdata),
        .i_byteenable(4'hF), .o_readdata(rdata), .o_waitrequest(waitreq),
        .o_response(resp), .o_strap_capture_low(cap_lo), .o_strap_capture_high(cap_hi),
        .o_capture_valid(cap_v));

    task automatic tally_and_finish;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // one avalon access; request held until waitrequest is seen low at an edge
    task automatic bus(input logic we, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] dq, output logic [1:0] dr);
        int n;
        n = 0;
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        rd    <= !we;
        wr    <= we;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 20);
        dq = rdata;
        dr = resp;
        rd <= 1'b0;
        wr <= 1'b0;
        if (waitreq !== 1'b0) begin
            error_cnt++;
            $display("mismatch at %0t: bus timeout", $time);
            tally_and_finish();
        end
    endtask

    task automatic chk(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] dq;
        logic [1:0]  dr;
        bus(1'b0, a, 32'h0, dq, dr);
        `CHK(dq, e)
        `CHK(dr, rsc_pkg::RSC_RESP_OKAY)
    endtask

    // board pulses its reset pin; captures land a fixed 3 edges after release
    task automatic strap(input logic [15:0] v);
        int n;
        n = 0;
        @(posedge clk);
        pat <= v;
        go  <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        do begin
            @(posedge clk);
            n++;
        end while (busy !== 1'b0 && n < 40);
        if (busy !== 1'b0) begin
            error_cnt++;
            $display("mismatch at %0t: strap timeout", $time);
            tally_and_finish();
        end
        repeat (4) @(posedge clk);
    endtask

    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 32; i++) begin
            p = (i < 16) ? (16'h1 << i) : ~(16'h1 << (i - 16));
            strap(p);
            `CHK({cap_v, cap_lo, cap_hi}, {1'b1, p})
            chk(rsc_pkg::RSC_ADDR_LOW, {24'h0, p[15:8]});
            chk(rsc_pkg::RSC_ADDR_HIGH, {24'h0, p[7:0]});
        end
        // writes with zeroed reserved bits are accepted and ignored
        bus(1'b1, rsc_pkg::RSC_ADDR_LOW, 32'h0000_0080, q, r);
        `CHK(r, rsc_pkg::RSC_RESP_OKAY)
        bus(1'b1, rsc_pkg::RSC_ADDR_HIGH, 32'h0000_0000, q, r);
        chk(rsc_pkg::RSC_ADDR_LOW, {24'h0, p[15:8]});
        chk(rsc_pkg::RSC_ADDR_HIGH, {24'h0, p[7:0]});
        // emulator and watchdog resets must leave the captures alone
        @(posedge clk);
        emu <= 1'b1;
        @(posedge clk);
        emu  <= 1'b0;
        wdog <= 1'b1;
        @(posedge clk);
        wdog <= 1'b0;
        repeat (6) @(posedge clk);
        chk(rsc_pkg::RSC_ADDR_LOW, {24'h0, p[15:8]});
        chk(rsc_pkg::RSC_ADDR_HIGH, {24'h0, p[7:0]});
        // status: done, both events, live pin high, 32 releases counted
        chk(rsc_pkg::RSC_ADDR_STATUS, 32'h0000_200F);
        bus(1'b1, rsc_pkg::RSC_ADDR_STATUS, 32'h0000_0007, q, r);
        chk(rsc_pkg::RSC_ADDR_STATUS, 32'h0000_2008);
        // unmapped word between the captures and status
        bus(1'b0, 32'h4000_0008, 32'h0, q, r);
        `CHK(r, rsc_pkg::RSC_RESP_DECERR)
        `CHK(q, 32'h0)
        tally_and_finish();
    end
endmodule

bind rsc_top rsc_chk #(.ADDR_W(ADDR_W), .CAP_W(CAP_W)) u_chk (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ext_reset_n(i_ext_reset_n),
    .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_response(o_response),
    .o_strap_capture_low(o_strap_capture_low), .o_strap_capture_high(o_strap_capture_high),
    .o_capture_valid(o_capture_valid));
